// ---- src/rdag_consts.svh ----
// Constants of the remote-terminal DMA address generator
// ============================================================
`ifndef RDAG_CONSTS_SVH
`define RDAG_CONSTS_SVH

// ============================================================
// Register byte offsets
`define RDAG_OFS_CTRL 4'h0
`define RDAG_OFS_STATUS 4'h4
`define RDAG_OFS_COUNT 4'h8
`define RDAG_OFS_CMD 4'hC

// ============================================================
// Field positions
`define RDAG_CW_RT_HI 15
`define RDAG_CW_RT_LO 11
`define RDAG_CW_TR 10
`define RDAG_CW_SA_HI 9
`define RDAG_CW_SA_LO 5
`define RDAG_CW_WC_HI 4
`define RDAG_CW_WC_LO 0
`define RDAG_CTRL_OVR 0
`define RDAG_CTRL_WID 1
`define RDAG_ST_ACTIVE 16
`define RDAG_ST_OE 17
`define RDAG_CNT_BYTE 16

// ============================================================
// Codes and reset values
`define RDAG_BCAST_ADDR 5'h1F
`define RDAG_MODE_SA_LO 5'h00
`define RDAG_MODE_SA_HI 5'h1F
`define RDAG_CTRL_RST 2'h0
`define RDAG_FIELD_RST 5'h00
`define RDAG_ADDR_RST 14'h0041

`endif

// ---- src/rdag_pkg.sv ----
// Types of the remote-terminal DMA address generator
`default_nettype none
package rdag_pkg;
    // Command sequencing states
    typedef enum logic [1:0] {
        RDAG_IDLE = 2'b00,
        RDAG_LATCH = 2'b01,
        RDAG_ACTIVE = 2'b10
    } rdag_state_t;
endpackage
`default_nettype wire

// ---- src/rdag_address_gen.sv ----
// Address generator for the parallel DMA side of a remote terminal
//
// Chosen here: register access over Avalon-MM and the register addresses.
`include "rdag_consts.svh"
`default_nettype none
module rdag_address_gen
    import rdag_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic resetn, // Async reset, active low
    // Avalon-MM slave
    input wire logic [3:0] avsAddress, // Byte address
    input wire logic avsRead, // Read request
    input wire logic avsWrite, // Write request
    input wire logic [3:0] avsByteenable, // Byte lanes
    input wire logic [31:0] avsWritedata, // Write data
    output logic [31:0] avsReaddata, // Read data
    output logic avsWaitrequest, // Stall
    // Terminal side
    input wire logic commandAcceptEvent, // Pulse: command word received
    input wire logic [15:0] commandWordIn, // Received command word
    input wire logic [4:0] terminalAddressIn, // Own terminal address
    input wire logic terminalAddressParityIn, // Address parity
    input wire logic commandPhase, // Command word on parallel bus
    input wire logic transferStrobe, // Pulse: one bus cycle done
    input wire logic handshakeTimeout, // Pulse: grant never came
    input wire logic messageDone, // Pulse: message complete
    input wire logic busWidthSelect, // 0 16-bit, 1 8-bit
    input wire logic addressDriveEnableN, // High lets lines float unless ack is low
    input wire logic transferAckN, // Transfer ack, active low
    input wire logic chipSelectInN, // Chip select from handshake
    input wire logic directionIn, // Direction from handshake
    output logic commandActive, // Command in progress
    output logic commandActiveAltN, // Same, active low
    output logic broadcastFlagOut, // Broadcast flag line
    output logic transmitFlagOut, // Transmit flag line
    output logic [4:0] subaddressOut, // Subaddress lines
    output logic commandTransferN, // Command-transfer strobe
    output logic [4:0] wordCountOut, // Word-count lines
    output logic byteSelectOut, // Byte select line
    output logic chipSelectN, // Chip select out
    output logic transferDirectionOut, // Direction out
    output logic addressOe // Drive enable of all lines above
);

    // ============================================================
    // Command decode
    logic [4:0] cwAddr;
    logic isBroadcast;
    logic isOwn;
    logic accept;

    assign cwAddr = commandWordIn[`RDAG_CW_RT_HI:`RDAG_CW_RT_LO];
    // All-ones address is broadcast
    assign isBroadcast = (cwAddr == `RDAG_BCAST_ADDR);
    // Own address only with a sound parity strap
    assign isOwn = (cwAddr == terminalAddressIn) && ^{terminalAddressIn, terminalAddressParityIn};

    // ============================================================
    // Command state and latched fields
    rdag_state_t state_q;
    rdag_state_t state_d;
    logic bcast_q;
    logic bcast_d;
    logic xmit_q;
    logic xmit_d;
    logic [4:0] subaddr_q;
    logic [4:0] subaddr_d;
    logic [4:0] wcField_q;
    logic [4:0] wcField_d;
    logic [15:0] cmdWord_q;
    logic [15:0] cmdWord_d;
    logic active_q;
    logic active_d;
    logic isMode;

    // A new command is taken only between messages
    assign accept = commandAcceptEvent && (state_q == RDAG_IDLE) && (isBroadcast || isOwn);
    assign isMode = (subaddr_q == `RDAG_MODE_SA_LO) || (subaddr_q == `RDAG_MODE_SA_HI);

    // Next command state; fields latch on the accept itself
    always_comb begin
        state_d = state_q;
        bcast_d = bcast_q;
        xmit_d = xmit_q;
        subaddr_d = subaddr_q;
        wcField_d = wcField_q;
        cmdWord_d = cmdWord_q;
        unique case (state_q)
            RDAG_IDLE: begin
                if (accept) begin
                    state_d = RDAG_LATCH;
                    bcast_d = isBroadcast;
                    xmit_d = commandWordIn[`RDAG_CW_TR];
                    subaddr_d = commandWordIn[`RDAG_CW_SA_HI:`RDAG_CW_SA_LO];
                    wcField_d = commandWordIn[`RDAG_CW_WC_HI:`RDAG_CW_WC_LO];
                    cmdWord_d = commandWordIn;
                end
            end
            // One cycle for the latched lines to settle first
            RDAG_LATCH: begin
                state_d = RDAG_ACTIVE;
            end
            RDAG_ACTIVE: begin
                if (messageDone) begin
                    state_d = RDAG_IDLE;
                end
            end
            default: begin
                state_d = RDAG_IDLE;
            end
        endcase
        // Visible flag rises one edge after the state, falls at the same edge as it
        active_d = (state_q == RDAG_ACTIVE) && !messageDone;
    end

    // Command state registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= RDAG_IDLE;
            bcast_q <= 1'b0;
            xmit_q <= 1'b0;
            subaddr_q <= `RDAG_FIELD_RST;
            wcField_q <= `RDAG_FIELD_RST;
            cmdWord_q <= 16'h0000;
            active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bcast_q <= bcast_d;
            xmit_q <= xmit_d;
            subaddr_q <= subaddr_d;
            wcField_q <= wcField_d;
            cmdWord_q <= cmdWord_d;
            active_q <= active_d;
        end
    end

    // ============================================================
    // Current word counter and byte phase
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic byteHi_q;
    logic byteHi_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic eightBit;
    logic running;

    // Software may override the width strap
    assign eightBit = ctrl_q[`RDAG_CTRL_OVR] ? ctrl_q[`RDAG_CTRL_WID] : busWidthSelect;
    assign running = (state_q == RDAG_ACTIVE);

    // Count data words; a lost handshake still uses up a slot
    always_comb begin
        count_d = count_q;
        byteHi_d = byteHi_q;
        if (state_q == RDAG_LATCH) begin
            count_d = 5'h00;
            byteHi_d = 1'b1;
        end else if (!running) begin
            byteHi_d = 1'b1;
        end else if (handshakeTimeout) begin
            count_d = count_q + 5'h01;
            byteHi_d = 1'b1;
        end else if (transferStrobe) begin
            if (eightBit && byteHi_q) begin
                byteHi_d = 1'b0;
            end else begin
                byteHi_d = 1'b1;
                if (!commandPhase && !isMode) begin
                    count_d = count_q + 5'h01;
                end
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 5'h00;
            byteHi_q <= 1'b1;
        end else begin
            count_q <= count_d;
            byteHi_q <= byteHi_d;
        end
    end

    // ============================================================
    // Address lines and three-state control
    logic cmdXfer;
    logic [4:0] wcLines;
    logic [13:0] addr_q;
    logic [13:0] addr_d;
    logic oe_q;
    logic oe_d;
    logic cs_q;
    logic cs_d;
    logic dir_q;
    logic dir_d;

    assign cmdXfer = running && commandPhase;

    // Word-count multiplexer, then the whole address word
    always_comb begin
        if (cmdXfer) begin
            wcLines = isMode ? wcField_q : 5'h00;
        end else if (running && !isMode) begin
            wcLines = count_q;
        end else begin
            wcLines = wcField_q;
        end
        // Strobe high on a data word puts a mode word 64 higher
        addr_d = {bcast_q, xmit_q, subaddr_q, !cmdXfer, wcLines,
                  eightBit ? byteHi_q : 1'b1};
        oe_d = !(addressDriveEnableN && transferAckN);
        cs_d = chipSelectInN;
        dir_d = directionIn;
    end

    // Output registers keep the pins glitch free
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= `RDAG_ADDR_RST;
            oe_q <= 1'b0;
            cs_q <= 1'b1;
            dir_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            oe_q <= oe_d;
            cs_q <= cs_d;
            dir_q <= dir_d;
        end
    end

    assign broadcastFlagOut = addr_q[13];
    assign transmitFlagOut = addr_q[12];
    assign subaddressOut = addr_q[11:7];
    assign commandTransferN = addr_q[6];
    assign wordCountOut = addr_q[5:1];
    assign byteSelectOut = addr_q[0];
    assign chipSelectN = cs_q;
    assign transferDirectionOut = dir_q;
    assign addressOe = oe_q;
    assign commandActive = active_q;
    assign commandActiveAltN = !active_q;

    // ============================================================
    // Avalon-MM slave: every access waits exactly one cycle
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic request;

    assign request = avsRead || avsWrite;
    assign avsWaitrequest = request && !ack_q;
    assign avsReaddata = rdata_q;

    // Read data is built in the wait cycle so it stands at the answer edge
    always_comb begin
        ack_d = request && !ack_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        if (avsRead && !ack_q) begin
            rdata_d = 32'h00000000;
            unique case (avsAddress)
                `RDAG_OFS_CTRL: begin
                    rdata_d[1:0] = ctrl_q;
                end
                `RDAG_OFS_STATUS: begin
                    rdata_d[13:0] = addr_q;
                    rdata_d[`RDAG_ST_ACTIVE] = active_q;
                    rdata_d[`RDAG_ST_OE] = oe_q;
                end
                `RDAG_OFS_COUNT: begin
                    rdata_d[4:0] = count_q;
                    rdata_d[12:8] = wcField_q;
                    rdata_d[`RDAG_CNT_BYTE] = byteHi_q;
                end
                `RDAG_OFS_CMD: begin
                    rdata_d[15:0] = cmdWord_q;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
        // Writes land at the answer edge, one edge after the wait ends
        if (avsWrite && ack_q && avsByteenable[0] && avsAddress == `RDAG_OFS_CTRL) begin
            ctrl_d = avsWritedata[1:0];
        end
    end

    // Bus registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            ctrl_q <= `RDAG_CTRL_RST;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/rdag_address_gen_monitor.sv ----
// Assertion checker for the DMA address generator
`default_nettype none
module rdag_address_gen_monitor (
    input wire logic clk, // Clock
    input wire logic chipSelectInN, // CS in
    input wire logic directionIn, // Dir in
    input wire logic chipSelectN, // CS out
    input wire logic transferDirectionOut, // Dir out
    input wire logic resetn, // Reset
    input wire logic commandAcceptEvent, // Accept
    input wire logic commandPhase, // Cmd word
    input wire logic messageDone, // End
    input wire logic busWidthSelect, // Width
    input wire logic addressDriveEnableN, // Float
    input wire logic transferAckN, // Ack
    input wire logic commandActive, // Active
    input wire logic commandActiveAltN, // Active low
    input wire logic broadcastFlagOut, // Bcast
    input wire logic [4:0] subaddressOut, // SA
    input wire logic commandTransferN, // Strobe
    input wire logic [4:0] wordCountOut, // WC
    input wire logic byteSelectOut, // Byte
    input wire logic addressOe // Drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Properties, one clock domain
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Mode code subaddresses
    wire modeSa = subaddressOut == 5'h00 || subaddressOut == 5'h1F;
    AST_ALT_N: assert property (commandActiveAltN != commandActive) else $error("active pair");
    // The edge that releases reset still loads the reset value, so skip it
    AST_OE: assert property ($past(resetn) |-> addressOe == !($past(addressDriveEnableN) && $past(transferAckN)))
        else $error("oe");
    AST_PASS_CS: assert property ($past(resetn) |-> chipSelectN == $past(chipSelectInN)) else $error("cs");
    AST_PASS_DIR: assert property ($past(resetn) |-> transferDirectionOut == $past(directionIn))
        else $error("dir");
    AST_RISE: assert property ($rose(commandActive) |-> $past(commandAcceptEvent, 3)) else $error("rise");
    AST_LATCHED: assert property ($rose(commandActive) |-> $stable(subaddressOut) && $stable(broadcastFlagOut))
        else $error("late latch");
    AST_ZERO: assert property ($rose(commandActive) && !modeSa |-> wordCountOut == 5'h00) else $error("wc");
    AST_CMD_N: assert property (commandActive && commandPhase [*2] |=> !commandTransferN) else $error("cmd");
    AST_CMD_WC: assert property (commandActive && !modeSa && commandPhase [*2] |=> wordCountOut == 5'h00)
        else $error("cmd wc");
    AST_DONE: assert property (commandActive && messageDone |=> !commandActive) else $error("done");
    AST_B16: assert property (!busWidthSelect [*3] |-> byteSelectOut) else $error("byte");
    // Main scenarios
    cover property ($rose(commandActive));
    cover property (commandActive && busWidthSelect && !byteSelectOut);
    cover property (commandActive && messageDone);
endmodule
bind rdag_address_gen rdag_address_gen_monitor i_rdag_address_gen_monitor (.*);
`default_nettype wire

// ---- testbench/rdag_dma_partner.sv ----
// Subsystem partner: acks each transfer after a random stall
`default_nettype none
module rdag_dma_partner (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic go, // Start a transfer
    input wire logic wide8, // Width wish
    output logic transferAckN, // Ack, low
    output logic transferStrobe, // Transfer done
    output logic busWidthSelect, // Width select
    output logic busy // In flight
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 97701;
    int stall;
    // Subsystem picks the width: low 16-bit, high 8-bit
    assign busWidthSelect = wide8;
    // Stall 0..3 cycles, so both prompt and slow answers occur
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transferAckN <= 1'b1;
            transferStrobe <= 1'b0;
            busy <= 1'b0;
        end else begin
            transferStrobe <= 1'b0;
            if (go) begin
                busy <= 1'b1;
                stall <= $random(seed) & 3;
            end else if (busy && stall > 0) begin
                stall <= stall - 1;
            end else if (busy && transferAckN) begin
                transferAckN <= 1'b0;
            end else if (busy) begin
                transferAckN <= 1'b1;
                transferStrobe <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the DMA address generator
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, avsRead, avsWrite, avsWaitrequest, commandAcceptEvent, terminalAddressParityIn;
    logic commandPhase, transferStrobe, handshakeTimeout, messageDone, busWidthSelect, addressDriveEnableN;
    logic transferAckN, chipSelectInN, directionIn, commandActive, commandActiveAltN, broadcastFlagOut;
    logic transmitFlagOut, commandTransferN, byteSelectOut, chipSelectN, transferDirectionOut, addressOe;
    logic go, wide8, busy;
    logic [3:0] avsAddress, avsByteenable;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [15:0] commandWordIn;
    logic [4:0] terminalAddressIn, subaddressOut, wordCountOut;
    logic [13:0] expL;
    int n_fail, checks, seed, cyc, cnt, ph;
    wire logic [13:0] lines = {broadcastFlagOut, transmitFlagOut, subaddressOut, commandTransferN,
        wordCountOut, byteSelectOut};
    rdag_address_gen i_rdag_address_gen (.*);
    rdag_dma_partner i_rdag_dma_partner (.*);
    // ============================================================
    // Clock, random pins, hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        {addressDriveEnableN, chipSelectInN, directionIn} <= 3'($random(seed));
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Request held until the edge that sees waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic cmd(input logic [15:0] w);
        logic ok;
        logic mc;
        @(posedge clk);
        commandWordIn <= w;
        commandAcceptEvent <= 1'b1;
        // Decided after the edge so a strap change made just before has landed
        ok = w[15:11] == 5'h1F || (w[15:11] == terminalAddressIn && ^{terminalAddressIn, terminalAddressParityIn});
        mc = w[9:5] == 5'h00 || w[9:5] == 5'h1F;
        @(posedge clk);
        commandAcceptEvent <= 1'b0;
        tick(1);
        if (ok) expL = {w[15:11] == 5'h1F, w[10:5], 1'b1, w[4:0], 1'b1};
        chk(lines, expL);
        tick(1);
        chk({commandActive, wordCountOut}, {ok, ok ? (mc ? w[4:0] : 5'h00) : expL[5:1]});
        if (!ok) return;
        @(posedge clk);
        commandPhase <= 1'b1;
        tick(2);
        chk({commandTransferN, wordCountOut}, {1'b0, mc ? w[4:0] : 5'h00});
        @(posedge clk);
        commandPhase <= 1'b0;
        cnt = 0;
        ph = 1;
        // Third slot of a data run is a handshake timeout
        for (int i = 0; i < (mc ? 1 : 5); i++) begin
            @(posedge clk);
            if (i == 2) handshakeTimeout <= 1'b1;
            else go <= 1'b1;
            @(posedge clk);
            handshakeTimeout <= 1'b0;
            go <= 1'b0;
            @(negedge clk);
            while (busy) @(negedge clk);
            tick(3);
            ph = (i == 2) ? 1 : ph ^ wide8;
            if (i == 2 || ph == 1) cnt++;
            if (!mc) chk({wordCountOut, byteSelectOut}, {cnt[4:0], ph[0]});
            else chk(lines, {expL[13:7], 1'b1, w[4:0], ph[0]});
        end
        @(posedge clk);
        messageDone <= 1'b1;
        @(posedge clk);
        messageDone <= 1'b0;
        tick(2);
        chk({commandActive, wordCountOut}, {1'b0, w[4:0]});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ============================================================
    // Main sequence
    initial begin
        logic [15:0] w;
        seed = 97701;
        resetn = 1'b0;
        {avsRead, avsWrite, commandAcceptEvent, commandPhase, handshakeTimeout, messageDone, go, wide8} = 8'h00;
        {addressDriveEnableN, chipSelectInN, directionIn} = 3'h7;
        avsAddress = 4'h0;
        avsByteenable = 4'hF;
        avsWritedata = 32'h0;
        commandWordIn = 16'h0;
        terminalAddressIn = 5'h0A;
        terminalAddressParityIn = 1'b1;
        expL = 14'h0041;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        tick(1);
        chk(lines, expL);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h2);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        $display("test bus done");
        // Own and broadcast, both widths, then both mode code subaddresses
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            wide8 <= k[0] && k < 6;
            w = 16'($random(seed));
            w[15:11] = k[1] ? 5'h1F : 5'h0A;
            if (k >= 6) w[9:5] = {5{k[0]}};
            cmd(w);
            $display("test command %0d done", k);
        end
        // Foreign address, then own address with even parity
        cmd(16'h5A42);
        @(posedge clk);
        terminalAddressParityIn <= 1'b0;
        cmd(16'h5442);
        $display("test refusals done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
